// ==== include/pcb_pkg.sv ====
package pcb_pkg;

    // Clock and timing
    localparam int CLK_PERIOD_PS = 40000;
    localparam int PHASE_ERR_PS = 700;
    localparam int PHASE_ERR_CYC_RAW = (PHASE_ERR_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int PHASE_ERR_CYC = (PHASE_ERR_CYC_RAW < 1) ? 1 : PHASE_ERR_CYC_RAW;
    localparam logic [3:0] PHASE_ERR_LIM = 4'(PHASE_ERR_CYC);
    localparam logic [2:0] LOCK_LOSS_ERRS = 3'h4;
    localparam logic [5:0] LOCK_GAIN_GOOD = 6'h20;
    localparam logic [2:0] TEST_RESET_EDGES = 3'h5;
    localparam logic [3:0] WDOG_REF_DIV_LAST = 4'hf;
    localparam logic [3:0] WDOG_TIMEOUT = 4'h8;

    // Register byte offsets
    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] DIV_OFS = 12'h004;
    localparam logic [11:0] STATUS_OFS = 12'h008;

    // Control register fields
    localparam int CTRL_OSC_RANGE = 0;
    localparam int CTRL_LOOP_EN = 1;
    localparam int CTRL_TEST_LO = 2;
    localparam int CTRL_TEST_HI = 3;
    localparam int CTRL_INVERT = 4;
    localparam int CTRL_RST_OE = 5;
    localparam int CTRL_REF_SRC = 6;
    localparam int CTRL_SE_SEL = 7;
    localparam logic [7:0] CTRL_RESET = 8'hef;

    // Divide register fields
    localparam int DIV_A_LO = 0;
    localparam int DIV_B_LO = 2;
    localparam int DIV_C_LO = 4;
    localparam int DIV_FB_LO = 6;
    localparam logic [8:0] DIV_RESET = 9'h000;

    // Status register fields
    localparam int STAT_FLAG = 0;
    localparam int STAT_LOCKED = 1;
    localparam int STAT_HELD = 2;
    localparam int STAT_ERR_LO = 4;
    localparam int STAT_GOOD_LO = 8;

    // Test reset sequencer
    typedef enum logic [2:0] {
        PCB_RUN  = 3'b001,
        PCB_WAIT = 3'b010,
        PCB_HELD = 3'b100
    } pcb_test_e;

endpackage

// ==== src/pcb_clock_ctrl.sv ====
`timescale 1ns/10ps
// What this block does
// - Range select high keeps full oscillator rate; low halves it.
// - Loop enable picks the oscillator; bypass picks the selected reference.
// - Test control bits have no effect while the loop is enabled.
// - Invert bit flips bank C upper pair against its lower pair only.
// - Bank C inversion applies after division, any divide ratio.
// - Reset/output-enable low resets and floats; high enables outputs.
// - Flag high while locked, low while acquiring.
// - Feedback edge too far from reference edge counts a phase error.
// - Locked: four consecutive error cycles drop the flag.
// - Unlocked: 32 consecutive clean feedback cycles raise the flag.
// - Watchdog on divided reference drops the flag if feedback stops.
// - Flag always driven, never floats, ignores reset/output-enable.
// - In bypass the flag pin shows test information.
// - Bypass ignores feedback input, other functions keep running.
// - Bypass reset floats outputs; five reference edges force known state.
// - Known state comes from divide selects and range select.
// - Held until release, then bypass operation resumes.
// - Three four-output banks with two-bit selects, feedback with three-bit.
// - Banks A/B divide 4,6,8,12/10; bank C divides 2,4,6,8.
// - Feedback divides 4,6,8,10,8,12,16,20 for codes 0 to 7.
// - Reference select picks differential or one of two single-ended inputs.
module pcb_clock_ctrl (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Reference and loop inputs
    input wire logic differential_reference,
    input wire logic ttl_reference_0,
    input wire logic ttl_reference_1,
    input wire logic loop_clock_in,
    input wire logic feedback_input,
    // Clock outputs
    output logic [3:0] bank_a_out,
    output logic [3:0] bank_b_out,
    output logic [3:0] bank_c_out,
    output logic feedback_output,
    output logic clk_oe_n,
    // Lock indicator
    output logic phase_aligned_flag
);
    import pcb_pkg::*;

    // Half-period in source edges for banks A and B
    function automatic logic [3:0] half_ab(input logic [1:0] sel, input logic is_b);
        unique case (sel)
            2'h0: half_ab = 4'h2;
            2'h1: half_ab = 4'h3;
            2'h2: half_ab = 4'h4;
            2'h3: half_ab = is_b ? 4'h5 : 4'h6;
        endcase
    endfunction

    // Half-period in source edges for bank C
    function automatic logic [3:0] half_c(input logic [1:0] sel);
        half_c = 4'({2'h0, sel} + 4'h1);
    endfunction

    // Half-period in source edges for feedback output
    function automatic logic [3:0] half_fb(input logic [2:0] sel);
        unique case (sel)
            3'h0: half_fb = 4'h2;
            3'h1: half_fb = 4'h3;
            3'h2: half_fb = 4'h4;
            3'h3: half_fb = 4'h5;
            3'h4: half_fb = 4'h4;
            3'h5: half_fb = 4'h6;
            3'h6: half_fb = 4'h8;
            3'h7: half_fb = 4'ha;
        endcase
    endfunction

    logic [7:0] ctrl_reg;
    logic [8:0] div_reg;
    logic pready_reg;
    logic [31:0] prdata_reg;
    logic pslverr_reg;
    logic ref_prev_reg;
    logic loop_prev_reg;
    logic fb_prev_reg;
    logic pre_reg;
    logic [3:0] cnt_reg [4];
    logic [3:0] lvl_reg;
    logic [3:0] bank_c_reg;
    logic clk_oe_n_reg;
    logic flag_reg;
    logic locked_reg;
    logic [2:0] err_run_reg;
    logic [5:0] good_run_reg;
    logic [3:0] since_ref_reg;
    logic [3:0] wd_div_reg;
    logic [3:0] wd_cnt_reg;
    logic [2:0] edge_cnt_reg;
    pcb_test_e test_reg;
    pcb_test_e test_next;

    // Control fields
    wire osc_range = ctrl_reg[CTRL_OSC_RANGE];
    wire loop_en = ctrl_reg[CTRL_LOOP_EN];
    wire [1:0] test_ctl = ctrl_reg[CTRL_TEST_HI:CTRL_TEST_LO];
    wire invert = ctrl_reg[CTRL_INVERT];
    wire rst_oe = ctrl_reg[CTRL_RST_OE];
    wire master_rst = ~rst_oe;

    // Reference selection
    wire ref_level = ctrl_reg[CTRL_REF_SRC] ? differential_reference :
        (ctrl_reg[CTRL_SE_SEL] ? ttl_reference_1 : ttl_reference_0);
    wire ref_rise = ref_level & ~ref_prev_reg;
    wire loop_rise = loop_clock_in & ~loop_prev_reg;
    wire vco_tick = loop_rise & (osc_range | pre_reg);
    wire src_tick = loop_en ? vco_tick : ref_rise;
    wire fb_rise = feedback_input & ~fb_prev_reg & loop_en;

    // Divider reload values per output
    wire [3:0] half [4];
    assign half[0] = half_ab(div_reg[DIV_A_LO +: 2], 1'b0);
    assign half[1] = half_ab(div_reg[DIV_B_LO +: 2], 1'b1);
    assign half[2] = half_c(div_reg[DIV_C_LO +: 2]);
    assign half[3] = half_fb(div_reg[DIV_FB_LO +: 3]);

    // Test reset sequencer decode
    wire held = (test_reg == PCB_HELD);
    wire div_clear = master_rst & loop_en;
    always_comb begin
        test_next = test_reg;
        unique case (test_reg)
            PCB_RUN: begin
                if (master_rst && !loop_en) begin
                    test_next = PCB_WAIT;
                end
            end
            PCB_WAIT: begin
                if (!master_rst || loop_en) begin
                    test_next = PCB_RUN;
                end else if (ref_rise && edge_cnt_reg == TEST_RESET_EDGES - 3'h1) begin
                    test_next = PCB_HELD;
                end
            end
            PCB_HELD: begin
                if (!master_rst || loop_en) begin
                    test_next = PCB_RUN;
                end
            end
            default: test_next = PCB_RUN;
        endcase
    end

    // Lock detector decode
    wire phase_ok = ref_rise | (since_ref_reg < PHASE_ERR_LIM);
    wire fb_err = fb_rise & ~phase_ok;
    wire fb_good = fb_rise & phase_ok;
    wire wd_tick = ref_rise & (wd_div_reg == WDOG_REF_DIV_LAST);
    wire wd_expire = wd_tick & (wd_cnt_reg == WDOG_TIMEOUT - 4'h1);
    wire lose = locked_reg & ((fb_err & (err_run_reg == LOCK_LOSS_ERRS - 3'h1)) | wd_expire);
    wire gain = ~locked_reg & fb_good & (good_run_reg == LOCK_GAIN_GOOD - 6'h1);
    wire locked_next = loop_en & (gain | (locked_reg & ~lose));
    wire test_info = test_ctl[1] ? held : lvl_reg[3];
    wire flag_next = loop_en ? locked_next : test_info;

    // APB decode
    wire setup = psel & ~penable;
    wire wr_en = psel & penable & pready_reg & pwrite;
    wire hit_ctrl = (paddr == CTRL_OFS);
    wire hit_div = (paddr == DIV_OFS);
    wire hit_stat = (paddr == STATUS_OFS);
    wire unmapped = ~(hit_ctrl | hit_div | hit_stat);
    wire [31:0] status_word = {18'h0, good_run_reg, 1'b0, err_run_reg, 1'b0,
        held, locked_reg, flag_reg};
    wire [31:0] rd_word = hit_ctrl ? {24'h0, ctrl_reg} :
        hit_div ? {23'h0, div_reg} : hit_stat ? status_word : 32'h0;

    // APB slave: one-cycle access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            prdata_reg <= 32'h0;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg <= setup;
            prdata_reg <= (setup && !pwrite) ? rd_word : 32'h0;
            pslverr_reg <= setup & unmapped;
        end
    end

    // Control and divide registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= CTRL_RESET;
            div_reg <= DIV_RESET;
        end else begin
            if (wr_en && hit_ctrl) begin
                ctrl_reg <= pwdata[7:0];
            end
            if (wr_en && hit_div) begin
                div_reg <= pwdata[8:0];
            end
        end
    end

    // Edge detection history
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_prev_reg <= 1'b0;
            loop_prev_reg <= 1'b0;
            fb_prev_reg <= 1'b0;
        end else begin
            ref_prev_reg <= ref_level;
            loop_prev_reg <= loop_clock_in;
            fb_prev_reg <= feedback_input;
        end
    end

    // Oscillator prescaler and output dividers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_reg <= 1'b0;
            lvl_reg <= 4'h0;
            for (int i = 0; i < 4; i++) begin
                cnt_reg[i] <= 4'h0;
            end
        end else if (div_clear || held) begin
            pre_reg <= ~div_clear & ~osc_range;
            lvl_reg <= 4'h0;
            for (int i = 0; i < 4; i++) begin
                cnt_reg[i] <= div_clear ? 4'h0 : half[i] - 4'h1;
            end
        end else begin
            pre_reg <= pre_reg ^ loop_rise;
            for (int i = 0; i < 4; i++) begin
                if (src_tick) begin
                    if (cnt_reg[i] >= half[i] - 4'h1) begin
                        cnt_reg[i] <= 4'h0;
                        lvl_reg[i] <= ~lvl_reg[i];
                    end else begin
                        cnt_reg[i] <= cnt_reg[i] + 4'h1;
                    end
                end
            end
        end
    end

    // Bank C phase and output enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bank_c_reg <= 4'h0;
            clk_oe_n_reg <= 1'b1;
        end else begin
            bank_c_reg <= {{2{lvl_reg[2] ^ invert}}, {2{lvl_reg[2]}}};
            clk_oe_n_reg <= master_rst;
        end
    end

    // Test reset sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            test_reg <= PCB_RUN;
            edge_cnt_reg <= 3'h0;
        end else begin
            test_reg <= test_next;
            if (test_reg != PCB_WAIT) begin
                edge_cnt_reg <= 3'h0;
            end else if (ref_rise) begin
                edge_cnt_reg <= edge_cnt_reg + 3'h1;
            end
        end
    end

    // Lock detector and watchdog
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            locked_reg <= 1'b0;
            err_run_reg <= 3'h0;
            good_run_reg <= 6'h0;
            since_ref_reg <= 4'hf;
            wd_div_reg <= 4'h0;
            wd_cnt_reg <= 4'h0;
            flag_reg <= 1'b0;
        end else begin
            locked_reg <= locked_next;
            flag_reg <= flag_next;
            since_ref_reg <= ref_rise ? 4'h0 :
                (since_ref_reg == 4'hf ? 4'hf : since_ref_reg + 4'h1);
            wd_div_reg <= wd_div_reg + {3'h0, ref_rise};
            if (fb_rise || !locked_reg) begin
                wd_cnt_reg <= 4'h0;
            end else if (wd_tick) begin
                wd_cnt_reg <= wd_cnt_reg + 4'h1;
            end
            if (fb_err && err_run_reg != 3'h7) begin
                err_run_reg <= err_run_reg + 3'h1;
            end else if (fb_good) begin
                err_run_reg <= 3'h0;
            end
            if (fb_err || locked_next) begin
                good_run_reg <= 6'h0;
            end else if (fb_good && good_run_reg != 6'h3f) begin
                good_run_reg <= good_run_reg + 6'h1;
            end
        end
    end

    // Outputs straight from flops
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign bank_a_out = {4{lvl_reg[0]}};
    assign bank_b_out = {4{lvl_reg[1]}};
    assign bank_c_out = bank_c_reg;
    assign feedback_output = lvl_reg[3];
    assign clk_oe_n = clk_oe_n_reg;
    assign phase_aligned_flag = flag_reg;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_last_edge;
        test_reg == PCB_WAIT && !loop_en && master_rst && ref_rise
            && edge_cnt_reg == TEST_RESET_EDGES - 3'h1;
    endsequence
    sequence s_held_stay;
        held && master_rst && !loop_en;
    endsequence

    property p_invert;
        1 |=> bank_c_out[2] == (bank_c_out[0] ^ $past(invert));
    endproperty
    a_invert: assert property (p_invert) else $error("bank C upper pair phase wrong");
    property p_float;
        master_rst |=> clk_oe_n;
    endproperty
    a_float: assert property (p_float) else $error("outputs not floated");
    property p_lose;
        locked_reg && fb_err && err_run_reg == 3'h3 |=> !locked_reg && !phase_aligned_flag;
    endproperty
    a_lose: assert property (p_lose) else $error("lock kept after four errors");
    property p_gain;
        $rose(locked_reg) |-> $past(good_run_reg) == 6'h1f;
    endproperty
    a_gain: assert property (p_gain) else $error("lock gained without 32 clean");
    property p_watchdog;
        locked_reg && wd_expire |=> !locked_reg;
    endproperty
    a_watchdog: assert property (p_watchdog) else $error("watchdog did not drop lock");
    property p_flag;
        loop_en |=> phase_aligned_flag == locked_reg;
    endproperty
    a_flag: assert property (p_flag) else $error("flag not lock state");
    property p_test_reset;
        s_last_edge |=> held ##1 (lvl_reg == 4'h0);
    endproperty
    a_test_reset: assert property (p_test_reset) else $error("no known state");
    property p_hold;
        s_held_stay |=> held && clk_oe_n;
    endproperty
    a_hold: assert property (p_hold) else $error("held state left early");
    property p_bypass_fb;
        !loop_en && !div_clear |=> locked_reg == 1'b0;
    endproperty
    a_bypass_fb: assert property (p_bypass_fb) else $error("lock moved in bypass");
endmodule

// ==== verification/pcb_ref_model.sv ====
`timescale 1ns/10ps
module pcb_ref_model (
    // Clock
    input wire logic pclk,
    // Feedback behaviour: 0 aligned, 1 three cycles late, 2 stopped
    input wire logic [1:0] fb_mode,
    // Reference and loop sources
    output logic differential_reference,
    output logic ttl_reference_0,
    output logic ttl_reference_1,
    output logic loop_clock_in,
    output logic feedback_input
);
    logic [7:0] ref_hist;
    int cnt;

    // Quiet sources at time zero
    initial begin
        cnt = 0;
        ref_hist = 8'h00;
        differential_reference = 1'b0;
        ttl_reference_0 = 1'b0;
        ttl_reference_1 = 1'b0;
        loop_clock_in = 1'b0;
        feedback_input = 1'b0;
    end

    // References of periods 8, 12 and 16 cycles; oscillator of period 2
    always @(posedge pclk) begin
        cnt <= cnt + 1;
        differential_reference <= (cnt % 8) >= 4;
        ttl_reference_0 <= (cnt % 12) >= 6;
        ttl_reference_1 <= (cnt % 16) >= 8;
        loop_clock_in <= ~loop_clock_in;
        ref_hist <= {ref_hist[6:0], (cnt % 8) >= 4};
        // Feedback follows the reference, lags it beyond the window, or stops low
        case (fb_mode)
            2'd0: feedback_input <= (cnt % 8) >= 4;
            2'd1: feedback_input <= ref_hist[2];
            default: feedback_input <= 1'b0;
        endcase
    end
endmodule

// ==== verification/tb.sv ====
`timescale 1ns/10ps
module tb;
    import pcb_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic diff_ref, ttl0, ttl1, loop_clk, fb_in, fb_out, clk_oe_n, flag;
    logic [3:0] bank_a, bank_b, bank_c;
    logic [1:0] fb_mode;
    int n_mismatch = 0;
    int check_count = 0;
    int per;

    // Block under test and its clock sources
    pcb_clock_ctrl uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .differential_reference(diff_ref), .ttl_reference_0(ttl0),
        .ttl_reference_1(ttl1), .loop_clock_in(loop_clk), .feedback_input(fb_in),
        .bank_a_out(bank_a), .bank_b_out(bank_b), .bank_c_out(bank_c),
        .feedback_output(fb_out), .clk_oe_n(clk_oe_n), .phase_aligned_flag(flag));
    pcb_ref_model ref_src (.pclk(pclk), .fb_mode(fb_mode), .differential_reference(diff_ref),
        .ttl_reference_0(ttl0), .ttl_reference_1(ttl1), .loop_clock_in(loop_clk),
        .feedback_input(fb_in));

    // 25 MHz clock
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // Verdict and end of run
    task automatic close_out();
        $display("Checks %0d, mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One APB transfer; read data and error land in rd and err
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            chk({31'h0, pready}, 32'h1);
        end
    endtask

    // Wait some edges, then sample at the falling edge
    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
    endtask

    function automatic logic pick(input int w);
        case (w)
            0: return bank_a[0];
            1: return bank_b[1];
            2: return bank_c[0];
            3: return fb_out;
            default: return bank_c[2];
        endcase
    endfunction

    // Cycles between the second and third rising edge of one output
    task automatic measure(input int w, output int p);
        logic prev;
        int n, last, r;
        p = 0;
        n = 0;
        last = 0;
        r = 0;
        prev = pick(w);
        while (r < 3 && n < 200) begin
            @(negedge pclk);
            n++;
            if (pick(w) === 1'b1 && prev === 1'b0) begin
                p = n - last;
                last = n;
                r++;
            end
            prev = pick(w);
        end
    endtask

    task automatic t_regs();
        apb(0, CTRL_OFS, 32'h0);
        chk(rd, 32'h0000_00ef);
        apb(0, 12'h00c, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        apb(1, DIV_OFS, 32'hffff_ffff);
        apb(0, DIV_OFS, 32'h0);
        chk(rd, 32'h0000_01ff);
        apb(1, DIV_OFS, 32'h0);
    endtask

    // Lock gained with test controls cleared while the loop runs
    task automatic t_lock();
        apb(1, CTRL_OFS, 32'he3);
        settle(150);
        chk({31'h0, flag}, 32'h0);
        settle(150);
        chk({31'h0, flag}, 32'h1);
        apb(0, STATUS_OFS, 32'h0);
        chk({31'h0, rd[1]}, 32'h1);
    endtask

    // Late feedback drops the flag after four errors, clean feedback relocks
    task automatic t_loss();
        @(posedge pclk);
        fb_mode <= 2'd1;
        settle(14);
        chk({31'h0, flag}, 32'h1);
        settle(40);
        chk({31'h0, flag}, 32'h0);
        @(posedge pclk);
        fb_mode <= 2'd0;
        settle(300);
        chk({31'h0, flag}, 32'h1);
    endtask

    // Output enable low floats the clocks but leaves the flag alone
    task automatic t_oe();
        apb(1, CTRL_OFS, 32'hc3);
        settle(3);
        chk({31'h0, clk_oe_n}, 32'h1);
        chk({31'h0, flag}, 32'h1);
        apb(1, CTRL_OFS, 32'he3);
        settle(2);
        chk({31'h0, clk_oe_n}, 32'h0);
        settle(300);
    endtask

    // Stopped feedback: watchdog of 8 ticks of reference/16
    task automatic t_wdog();
        @(posedge pclk);
        fb_mode <= 2'd2;
        settle(800);
        chk({31'h0, flag}, 32'h1);
        settle(350);
        chk({31'h0, flag}, 32'h0);
        @(posedge pclk);
        fb_mode <= 2'd0;
    endtask

    // Divide ratios, range select and bank C inversion; one tick is 2 cycles
    task automatic t_div();
        int ra[4] = '{4, 6, 8, 12};
        int rb[4] = '{4, 6, 8, 10};
        int rc[4] = '{2, 4, 6, 8};
        int rf[8] = '{4, 6, 8, 10, 8, 12, 16, 20};
        for (int s = 0; s < 4; s++) begin
            apb(1, DIV_OFS, 32'(s * 21));
            measure(0, per);
            chk(32'(per), 32'(2 * ra[s]));
            measure(1, per);
            chk(32'(per), 32'(2 * rb[s]));
            measure(2, per);
            chk(32'(per), 32'(2 * rc[s]));
        end
        for (int f = 0; f < 8; f++) begin
            apb(1, DIV_OFS, 32'(f << 6));
            measure(3, per);
            chk(32'(per), 32'(2 * rf[f]));
        end
        apb(1, CTRL_OFS, 32'he2);
        apb(1, DIV_OFS, 32'h0);
        measure(2, per);
        chk(32'(per), 32'd8);
        apb(1, CTRL_OFS, 32'hf3);
        apb(1, DIV_OFS, 32'h20);
        measure(4, per);
        chk(32'(per), 32'd12);
        for (int i = 0; i < 12; i++) begin
            @(negedge pclk);
            chk({30'h0, bank_c[3:2]}, {30'h0, ~bank_c[1:0]});
            chk({28'h0, bank_a}, {28'h0, {4{bank_a[0]}}});
        end
        apb(1, CTRL_OFS, 32'he3);
        settle(3);
        chk({30'h0, bank_c[3:2]}, {30'h0, bank_c[1:0]});
    endtask

    // Bypass with test reset, release, then each reference source
    task automatic t_byp();
        logic last_fb;
        @(posedge pclk);
        fb_mode <= 2'd2;
        apb(1, DIV_OFS, 32'h0);
        apb(1, CTRL_OFS, 32'hcd);
        settle(2);
        chk({31'h0, clk_oe_n}, 32'h1);
        settle(20);
        chk({31'h0, flag}, 32'h0);
        settle(30);
        chk({31'h0, flag}, 32'h1);
        chk({28'h0, bank_c}, 32'h0);
        apb(0, STATUS_OFS, 32'h0);
        chk({31'h0, rd[2]}, 32'h1);
        chk({31'h0, clk_oe_n}, 32'h1);
        apb(1, CTRL_OFS, 32'hed);
        settle(2);
        chk({31'h0, clk_oe_n}, 32'h0);
        chk({31'h0, flag}, 32'h0);
        measure(2, per);
        chk(32'(per), 32'd16);
        apb(1, CTRL_OFS, 32'h2d);
        measure(2, per);
        chk(32'(per), 32'd24);
        apb(1, CTRL_OFS, 32'had);
        measure(2, per);
        chk(32'(per), 32'd32);
        // Test control high bit clear: flag pin follows the feedback output one cycle later
        apb(1, CTRL_OFS, 32'he5);
        settle(1);
        for (int i = 0; i < 40; i++) begin
            last_fb = fb_out;
            @(negedge pclk);
            chk({31'h0, flag}, {31'h0, last_fb});
        end
    endtask

    // Main sequence
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        fb_mode = 2'd0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_lock();
        t_loss();
        t_oe();
        t_wdog();
        t_div();
        t_byp();
        close_out();
    end

    // Hang guard, well beyond the expected run
    initial begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        close_out();
    end
endmodule
